/* fldti_pkg.sv */
// Overview of operation
// - lane A bytes are captured on both edges of the lane A transmit clock.
// - with channel sync off, lanes B to D use both edges of their own clock.
// - with channel sync on, lanes B to D data use both lane A clock edges.
// - ninth and tenth bits of lanes B to D follow their data's clock choice.
// - with encoding off, the ninth line is bit nine of a ready 10-bit word.
// - with encoding on, a high ninth line makes the byte a K character.
// - the tenth line is bit ten with encoding off and ignored with it on.
// - a high encode-enable level switches the 8b/10b encoder on.
// - with channel sync on, all four lanes latch on lane A clock edges.
package fldti_pkg;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       tenth;
      logic       ninth;               // special_char_flag when encoding
      logic [7:0] data;
   } fldti_lane_in_s;

   typedef struct packed {
      logic       valid;               // pair was latched on this clock
      logic [9:0] first;               // rising-edge word, bit 9 sent first
      logic [9:0] second;              // falling-edge word
   } fldti_pair_s;

   // ----------------------------------------------------------------
   // capture instance roles
   // ----------------------------------------------------------------
   localparam logic [1:0] FLDTI_ACT_ALWAYS = 2'h0;
   localparam logic [1:0] FLDTI_ACT_SYNC   = 2'h1;
   localparam logic [1:0] FLDTI_ACT_NOSYNC = 2'h2;
   localparam int         FLDTI_LANES      = 4;

   // ----------------------------------------------------------------
   // 8b/10b code tables, negative running disparity forms
   // ----------------------------------------------------------------
   localparam logic [5:0] FLDTI_ENC6 [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] FLDTI_ENC4 [8] = '{
      4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   localparam logic [3:0] FLDTI_ALT7     = 4'h7;
   localparam logic [5:0] FLDTI_K28_6B   = 6'h0f;
   localparam logic [4:0] FLDTI_X_K28    = 5'h1c;
   localparam logic [4:0] FLDTI_X_D7     = 5'h07;
   localparam logic [2:0] FLDTI_Y_3      = 3'h3;
   localparam logic [2:0] FLDTI_Y_7      = 3'h7;
   localparam int         FLDTI_HALF6    = 3;
   localparam int         FLDTI_HALF4    = 2;
   localparam int         FLDTI_HALF10   = 5;
   localparam logic [9:0] FLDTI_K285_NEG = 10'h0fa;
   localparam logic [6:0] FLDTI_COMMA_N  = 7'h1f;
   localparam logic [6:0] FLDTI_COMMA_P  = 7'h60;
   localparam logic [7:0] FLDTI_K285_IN  = 8'hbc;

   // encodes one byte, returns {running disparity out, 10-bit word}
   function automatic logic [10:0] fldti_enc(input logic [7:0] d,
                                             input logic       k,
                                             input logic       rd);
      logic [4:0] x;
      logic [2:0] y;
      logic       k28;
      logic       r;
      logic       alt;
      logic [5:0] c6;
      logic [3:0] c4;
      logic [9:0] w;
      x   = d[4:0];
      y   = d[7:5];
      k28 = k && (x == FLDTI_X_K28);
      r   = rd && !k28;                // K28 built at rd- then inverted
      c6  = k28 ? FLDTI_K28_6B : FLDTI_ENC6[x];
      if (r && (($countones(c6) != FLDTI_HALF6) || (x == FLDTI_X_D7))) begin
         c6 = ~c6;
      end
      r   = r ^ ($countones(c6) != FLDTI_HALF6);
      alt = (y == FLDTI_Y_7) &&
            (k || (!r && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
             (r && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
      c4  = alt ? FLDTI_ALT7 : FLDTI_ENC4[y];
      if (r && (($countones(c4) != FLDTI_HALF4) || (y == FLDTI_Y_3))) begin
         c4 = ~c4;
      end
      w = {c6, c4};
      if (k28 && rd) begin
         w = ~w;
      end
      return {rd ^ ($countones(w) != FLDTI_HALF10), w};
   endfunction : fldti_enc

endpackage : fldti_pkg

/* fldti_top.sv */
// ---------------------------------------------------------------------
// one double-edge capture and encode stage on one transmit clock
// ---------------------------------------------------------------------
module fldti_lane
   import fldti_pkg::*;
#(
   parameter logic [1:0] ACT_MODE = FLDTI_ACT_ALWAYS
) (
   input  wire logic           lclk,
   input  wire logic           rst_req,
   input  wire logic           enc_pin,
   input  wire logic           sync_pin,
   input  wire fldti_lane_in_s din,
   output fldti_pair_s         pair_out
);

   logic           rst_meta_reg;
   logic           rst_reg;
   logic           enc_meta_reg;
   logic           enc_reg;
   logic           sync_meta_reg;
   logic           sync_reg;
   logic           act_reg;
   logic           rd_reg;
   fldti_lane_in_s rise_reg;
   fldti_lane_in_s fall_reg;
   logic [10:0]    enc_first;
   logic [10:0]    enc_second;

   // two-flop crossings of reset and the static mode pins
   always_ff @(posedge lclk) begin
      rst_meta_reg  <= rst_req;
      rst_reg       <= rst_meta_reg;
      enc_meta_reg  <= enc_pin;
      enc_reg       <= enc_meta_reg;
      sync_meta_reg <= sync_pin;
      sync_reg      <= sync_meta_reg;
   end

   // this stage owns the lane only in its clock-selection mode
   always_ff @(posedge lclk) begin
      if (rst_reg) begin
         act_reg <= 1'b0;
      end else begin
         case (ACT_MODE)
            FLDTI_ACT_SYNC:   act_reg <= sync_reg;
            FLDTI_ACT_NOSYNC: act_reg <= !sync_reg;
            default:          act_reg <= 1'b1;
         endcase
      end
   end

   // rising edge sample, all ten lines together
   always_ff @(posedge lclk) begin
      rise_reg <= din;
   end

   // falling edge sample, all ten lines together
   always_ff @(negedge lclk) begin
      fall_reg <= din;
   end

   // encode rising word first, falling word carries its disparity on
   always_comb begin
      enc_first  = fldti_enc(rise_reg.data, rise_reg.ninth, rd_reg);
      enc_second = fldti_enc(fall_reg.data, fall_reg.ninth,
                             enc_first[10]);
   end

   // output pair and running disparity
   always_ff @(posedge lclk) begin
      if (rst_reg) begin
         pair_out <= '0;
         rd_reg   <= 1'b0;
      end else begin
         pair_out.valid <= act_reg;
         if (act_reg && enc_reg) begin
            pair_out.first  <= enc_first[9:0];
            pair_out.second <= enc_second[9:0];
            rd_reg          <= enc_second[10];
         end else if (act_reg) begin
            pair_out.first  <= rise_reg;
            pair_out.second <= fall_reg;
         end
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence raw_step_s;
      act_reg && !enc_reg;
   endsequence

   sequence enc_step_s;
      act_reg && enc_reg;
   endsequence

   sequence idle_run_s;
      !act_reg [*2];
   endsequence

   raw_first_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      raw_step_s |=> pair_out.first == $past(din, 2))
      else $error("raw rising word not passed unchanged");

   raw_second_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      raw_step_s |=> pair_out.second == $past(fall_reg))
      else $error("raw falling word not passed unchanged");

   balance_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      enc_step_s |=> $countones(pair_out.first) inside {4, 5, 6} &&
                     $countones(pair_out.second) inside {4, 5, 6})
      else $error("encoded word out of disparity range");

   comma_k_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      enc_step_s ##0 (rise_reg.ninth && !rd_reg &&
                      rise_reg.data == FLDTI_K285_IN)
      |=> pair_out.first == FLDTI_K285_NEG)
      else $error("flagged byte not sent as K character");

   comma_data_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      enc_step_s ##0 !rise_reg.ninth
      |=> pair_out.first[9:3] != FLDTI_COMMA_N &&
          pair_out.first[9:3] != FLDTI_COMMA_P)
      else $error("data byte produced a comma");

   valid_gate_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      idle_run_s |=> !pair_out.valid && $stable(rd_reg))
      else $error("inactive stage delivered a pair");

   rd_track_a: assert property (
      @(posedge lclk) disable iff (rst_reg)
      enc_step_s |=> rd_reg == ($past(rd_reg) ^
                     ($countones(pair_out.first) != FLDTI_HALF10) ^
                     ($countones(pair_out.second) != FLDTI_HALF10)))
      else $error("running disparity lost track");

   reset_clear_a: assert property (
      @(posedge lclk)
      rst_reg |=> !pair_out.valid && !rd_reg && !act_reg)
      else $error("reset did not clear the stage");

endmodule : fldti_lane

// ---------------------------------------------------------------------
// four-lane transmit input
// ---------------------------------------------------------------------
module fldti_top
   import fldti_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        lane_a_tx_clock,
   input  wire logic        lane_b_tx_clock,
   input  wire logic        lane_c_tx_clock,
   input  wire logic        lane_d_tx_clock,
   input  wire logic [7:0]  lane_a_tx_byte,
   input  wire logic [7:0]  lane_b_tx_byte,
   input  wire logic [7:0]  lane_c_tx_byte,
   input  wire logic [7:0]  lane_d_tx_byte,
   input  wire logic [3:0]  special_char_flag,
   input  wire logic [3:0]  lane_tenth_bit,
   input  wire logic        encode_enable,
   input  wire logic        channel_sync_enable,
   output fldti_pair_s      sync_pair [FLDTI_LANES],
   output fldti_pair_s      own_pair  [1:FLDTI_LANES-1]
);

   logic           rst_hold_reg;
   logic           lane_clk [FLDTI_LANES];
   fldti_lane_in_s lane_in  [FLDTI_LANES];

   // reset registered on the system clock before it crosses
   always_ff @(posedge clk) begin
      rst_hold_reg <= sys_rst;
   end

   // gather the lane pins into carriers
   assign lane_clk[0] = lane_a_tx_clock;
   assign lane_clk[1] = lane_b_tx_clock;
   assign lane_clk[2] = lane_c_tx_clock;
   assign lane_clk[3] = lane_d_tx_clock;
   assign lane_in[0]  = {lane_tenth_bit[0], special_char_flag[0],
                         lane_a_tx_byte};
   assign lane_in[1]  = {lane_tenth_bit[1], special_char_flag[1],
                         lane_b_tx_byte};
   assign lane_in[2]  = {lane_tenth_bit[2], special_char_flag[2],
                         lane_c_tx_byte};
   assign lane_in[3]  = {lane_tenth_bit[3], special_char_flag[3],
                         lane_d_tx_byte};

   // stages on the lane A clock, all lanes
   for (genvar i = 0; i < FLDTI_LANES; i++) begin : g_sync
      fldti_lane #(
         .ACT_MODE ((i == 0) ? FLDTI_ACT_ALWAYS : FLDTI_ACT_SYNC)
      ) u_cap (
         .lclk     (lane_a_tx_clock),
         .rst_req  (rst_hold_reg),
         .enc_pin  (encode_enable),
         .sync_pin (channel_sync_enable),
         .din      (lane_in[i]),
         .pair_out (sync_pair[i])
      );
   end

   // stages on each lane's own clock, lanes B to D
   for (genvar i = 1; i < FLDTI_LANES; i++) begin : g_own
      fldti_lane #(
         .ACT_MODE (FLDTI_ACT_NOSYNC)
      ) u_cap (
         .lclk     (lane_clk[i]),
         .rst_req  (rst_hold_reg),
         .enc_pin  (encode_enable),
         .sync_pin (channel_sync_enable),
         .din      (lane_in[i]),
         .pair_out (own_pair[i])
      );
   end

endmodule : fldti_top

/* fldti_src.sv */
// ---------------------------------------------------------------------
// far-side lane source: free-running lane clock plus ddr lane word
// ---------------------------------------------------------------------
module fldti_src
   import fldti_pkg::*;
#(
   parameter int PH = 0
) (
   output logic           own_clk,
   input  wire logic      ref_clk,
   input  wire logic      sync,
   input  wire logic      enc,
   input  wire logic      quiet,
   output fldti_lane_in_s lane
);
   timeunit 1ns;
   timeprecision 100ps;

   wire logic   tck;
   logic [31:0] rnd;

   // launch clock: own one, or lane a clock in sync mode
   assign tck = sync ? ref_clk : own_clk;

   // lane clock, 30 ns period, free running
   initial begin
      own_clk = 1'b0;
      lane    = '0;
      #(PH);
      forever #15 own_clk = ~own_clk;
   end

   // new word mid-way between capture edges on both edges
   always @(posedge tck or negedge tck) begin
      #7;
      rnd = $urandom;
      lane.tenth <= rnd[9];
      lane.ninth <= quiet ? 1'b0 : rnd[8];
      lane.data  <= enc ? FLDTI_K285_IN : rnd[7:0];
   end

endmodule : fldti_src

/* four_lane_ddr_transmit_input_tb.sv */
module four_lane_ddr_transmit_input_tb;
   import fldti_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic            clk;
   logic            sys_rst;
   logic            encode_enable;
   logic            channel_sync_enable;
   logic            quiet;
   logic            chk;
   wire logic [3:0] lck;
   fldti_lane_in_s  din       [4];
   fldti_pair_s     sync_pair [FLDTI_LANES];
   fldti_pair_s     own_pair  [1:FLDTI_LANES-1];
   int              num_errors;
   int              checked;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // expected word: raw bits, or k28.5 / d28.5 code with disparity
   function automatic logic [9:0] exp_w(input fldti_lane_in_s d,
                                        inout logic rd);
      logic [9:0] w;
      if (!encode_enable) return {d.tenth, d.ninth, d.data};
      if (!d.ninth) return 10'h0ea; // d28.5 is neutral
      w  = rd ? ~FLDTI_K285_NEG : FLDTI_K285_NEG;
      rd = ~rd;
      return w;
   endfunction : exp_w

   task automatic cmp(input string nm, input logic [20:0] exp,
                      input logic [20:0] got);
      checked++;
      if (exp !== got) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // sources and design
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : src_g
      fldti_src #(.PH(3 + i * 4)) src_u (
         .own_clk (lck[i]),
         .ref_clk (lck[0]),
         .sync    (i == 0 ? 1'b1 : channel_sync_enable),
         .enc     (encode_enable),
         .quiet   (quiet),
         .lane    (din[i])
      );
   end

   fldti_top dut_u (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .lane_a_tx_clock     (lck[0]),
      .lane_b_tx_clock     (lck[1]),
      .lane_c_tx_clock     (lck[2]),
      .lane_d_tx_clock     (lck[3]),
      .lane_a_tx_byte      (din[0].data),
      .lane_b_tx_byte      (din[1].data),
      .lane_c_tx_byte      (din[2].data),
      .lane_d_tx_byte      (din[3].data),
      .special_char_flag   ({din[3].ninth, din[2].ninth,
                             din[1].ninth, din[0].ninth}),
      .lane_tenth_bit      ({din[3].tenth, din[2].tenth,
                             din[1].tenth, din[0].tenth}),
      .encode_enable       (encode_enable),
      .channel_sync_enable (channel_sync_enable),
      .sync_pair           (sync_pair),
      .own_pair            (own_pair)
   );

   // ----------------------------------------------------------------
   // monitors: stages 0-3 on lane a clock, 4-6 on own clocks
   // ----------------------------------------------------------------
   for (genvar s = 0; s < 7; s++) begin : mon_g
      localparam int LN = s < 4 ? s : s - 3;
      wire logic      ck;
      fldti_pair_s    got;
      fldti_lane_in_s rc;
      fldti_lane_in_s fc;
      logic           rd;
      logic           act;
      logic [9:0]     e1;
      logic [9:0]     e2;
      assign ck = s < 4 ? lck[0] : lck[LN];
      if (s < 4) begin : sy_g
         assign got = sync_pair[s];
      end else begin : ow_g
         assign got = own_pair[s - 3];
      end
      always @(negedge ck) fc = din[LN];
      // compare last rise/fall capture, then take this rise sample
      always @(posedge ck) begin
         #1;
         act = (s == 0) || ((s < 4) == channel_sync_enable);
         if (sys_rst) rd = 1'b0;
         if (chk && act) begin
            // rising word first so disparity runs in send order
            e1 = exp_w(rc, rd);
            e2 = exp_w(fc, rd);
            cmp("pair", {1'b1, e1, e2}, got);
         end else if (chk) begin
            cmp("idle valid", 21'h0, {20'h0, got.valid});
         end
         rc = din[LN];
      end
   end

   // ----------------------------------------------------------------
   // main sequence: raw/encoded crossed with own/sync clocking
   // ----------------------------------------------------------------
   always #50 clk = ~clk;

   initial begin
      clk                 = 1'b0;
      sys_rst             = 1'b1;
      encode_enable       = 1'b0;
      channel_sync_enable = 1'b0;
      quiet               = 1'b1;
      chk                 = 1'b0;
      num_errors          = 0;
      checked             = 0;
      void'($urandom(32'h9cdd_dd04));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         // flush the pipes with neutral words while still checking
         quiet               <= 1'b1;
         repeat (3) @(posedge clk);
         chk                 <= 1'b0;
         encode_enable       <= m[1];
         channel_sync_enable <= m[0];
         repeat (20) @(posedge clk);
         chk   <= 1'b1;
         quiet <= 1'b0;
         repeat (200) @(posedge clk);
      end
      stop_test();
   end

endmodule : four_lane_ddr_transmit_input_tb
